// [src/fdms_sequencer.sv]
// fdms_sequencer: command sequencer for the 4-byte-page data flash and download mode.
// Assumes a byte-wide flash macro with one-cycle read latency on the same clock,
// and a core that holds off instructions and interrupts while o_core_stall is high.
//
// Operation
// - page address comes from a high byte and a low byte register
// - command 1 copies the addressed page into the four data registers
// - a byte is programmed only while it holds FFH
// - erase always clears a whole page of four bytes
// - command 5 erases the page, command 2 programs the four data bytes
// - command 4 compares page; command register then reads zero on match
// - command 06H erases the whole 4-kbyte data array
// - page read/compare 25 cycles, page write 380 us, erases 2 ms
// - byte read 10 cycles, byte write 200 us
// - download mode: page write 15 ms, page erase and full erase 2 ms
// - an operation starts on the command write itself
// - core is held idle from command write until the operation completes
// - interrupts are held off until the operation finishes
// - timers and other peripherals keep running during the stall
// - data array is 1024 pages of four bytes, four data registers
// - F0H enters download mode, 0FH returns to normal, normal after reset
// - 81H reads one byte into first data register, 82H writes it
`timescale 1ns/1ps
`default_nettype none

module fdms_sequencer #(
  parameter logic [fdms_pkg::CNT_W-1:0] P_ERASE_CYC = fdms_pkg::CNT_W'(fdms_pkg::ERASE_CYC),
  parameter logic [fdms_pkg::CNT_W-1:0] P_PROGRAM_DOWNLOAD_MODE_WR_CYC =
    fdms_pkg::CNT_W'(fdms_pkg::PROGRAM_DOWNLOAD_MODE_WR_CYC)
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_reg_wr,
  input wire logic [2:0] i_reg_sel,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [7:0] i_mem_rdata,
  output logic [7:0] o_page_addr_high,
  output logic [7:0] o_page_addr_low,
  output logic [31:0] o_page_data_bytes,
  output logic [7:0] o_flash_command_reg,
  output logic o_program_download_mode,
  output logic o_prog_fault,
  output logic o_core_stall,
  output logic o_irq_hold,
  output logic [15:0] o_mem_addr,
  output logic [7:0] o_mem_wdata,
  output logic o_mem_rd,
  output logic o_mem_wr,
  output logic o_mem_erase_page,
  output logic o_mem_erase_all,
  output logic o_mem_page_load
);
  import fdms_pkg::*;

  typedef struct packed {
    fdms_state_e st;
    logic [7:0] addr_hi;
    logic [7:0] addr_lo;
    logic [PAGE_BYTES-1:0][7:0] data;
    logic [7:0] cmd;
    logic program_download_mode;
    logic [1:0] idx;
    logic phase;
    logic bytes_done;
    logic mismatch;
    logic fault;
  } fdms_seq_s;

  fdms_seq_s s_q;
  fdms_seq_s s_d;
  logic cmd_wr;
  logic starts_op;
  logic byte_loop;
  logic one_byte;
  logic tmr_load;
  logic tmr_expired;
  logic [CNT_W-1:0] tmr_count;
  logic [9:0] page_idx;

  ////////////////////////////////////////////////////////////////////////////////
  // command decode

  assign cmd_wr = i_reg_wr && (i_reg_sel == SEL_CMD) && (s_q.st == FDMS_IDLE);
  assign page_idx = {s_q.addr_hi[1:0], s_q.addr_lo};

  // download mode leaves reads and compares unimplemented: they start nothing
  function automatic logic is_op(input logic [7:0] c, input logic ul);
    case (c)
      CMD_PAGE_PROGRAM, CMD_PAGE_ERASE, CMD_ERASE_WHOLE, CMD_BYTE_PROGRAM: is_op = 1'b1;
      CMD_PAGE_READ, CMD_PAGE_COMPARE, CMD_BYTE_READ: is_op = !ul;
      default: is_op = 1'b0;
    endcase
  endfunction : is_op

  assign starts_op = cmd_wr && is_op(i_reg_wdata, s_q.program_download_mode);
  assign tmr_load = starts_op;

  always_comb begin
    case (i_reg_wdata)
      CMD_PAGE_READ, CMD_PAGE_COMPARE: tmr_count = CNT_W'(PAGE_RD_MC);
      CMD_PAGE_PROGRAM: tmr_count = s_q.program_download_mode ? P_PROGRAM_DOWNLOAD_MODE_WR_CYC : CNT_W'(PAGE_WR_CYC);
      CMD_PAGE_ERASE, CMD_ERASE_WHOLE: tmr_count = P_ERASE_CYC;
      CMD_BYTE_READ: tmr_count = CNT_W'(BYTE_RD_MC);
      CMD_BYTE_PROGRAM: tmr_count = CNT_W'(BYTE_WR_CYC);
      default: tmr_count = CNT_W'(1);
    endcase
  end

  // byte-wise accesses: normal page read/program/compare and single-byte ops in either mode
  assign one_byte = (s_q.cmd == CMD_BYTE_READ) || (s_q.cmd == CMD_BYTE_PROGRAM);
  assign byte_loop = one_byte || (!s_q.program_download_mode && ((s_q.cmd == CMD_PAGE_READ)
    || (s_q.cmd == CMD_PAGE_PROGRAM) || (s_q.cmd == CMD_PAGE_COMPARE)));

  ////////////////////////////////////////////////////////////////////////////////
  // sequencer

  always_comb begin
    s_d = s_q;
    case (s_q.st)
      FDMS_IDLE: begin
        if (i_reg_wr && !cmd_wr) begin
          case (i_reg_sel)
            SEL_ADDR_HIGH: s_d.addr_hi = i_reg_wdata;
            SEL_ADDR_LOW: s_d.addr_lo = i_reg_wdata;
            SEL_CMD: s_d.cmd = i_reg_wdata;
            default: begin
              if (i_reg_sel >= SEL_DATA0 && i_reg_sel < SEL_CMD) begin
                s_d.data[2'(i_reg_sel - SEL_DATA0)] = i_reg_wdata;
              end
            end
          endcase
        end
        if (cmd_wr) begin
          s_d.cmd = i_reg_wdata;
          if (i_reg_wdata == CMD_DOWNLOAD) begin
            s_d.program_download_mode = 1'b1;
          end else if (i_reg_wdata == CMD_EXIT_DOWNLOAD) begin
            s_d.program_download_mode = 1'b0;
          end
          if (starts_op) begin
            s_d.st = FDMS_WORK;
            s_d.idx = 2'h0;
            s_d.phase = 1'b0;
            s_d.bytes_done = 1'b0;
            s_d.mismatch = 1'b0;
            s_d.fault = 1'b0;
          end
        end
      end
      FDMS_WORK: begin
        if (!s_q.bytes_done) begin
          if (!byte_loop) begin
            s_d.bytes_done = 1'b1; // single pulse to the macro
          end else if (!s_q.phase) begin
            s_d.phase = 1'b1;
          end else begin
            s_d.phase = 1'b0;
            case (s_q.cmd)
              CMD_PAGE_READ, CMD_BYTE_READ: s_d.data[s_q.idx] = i_mem_rdata;
              CMD_PAGE_COMPARE: begin
                if (i_mem_rdata != s_q.data[s_q.idx]) begin
                  s_d.mismatch = 1'b1;
                end
              end
              default: begin
                if (i_mem_rdata != ERASED_BYTE) begin
                  s_d.fault = 1'b1;
                end
              end
            endcase
            if (one_byte || s_q.idx == 2'(PAGE_BYTES - 1)) begin
              s_d.bytes_done = 1'b1;
            end else begin
              s_d.idx = s_q.idx + 2'h1;
            end
          end
        end else if (tmr_expired) begin
          s_d.st = FDMS_DONE;
        end
      end
      FDMS_DONE: begin
        s_d.st = FDMS_IDLE;
        if (s_q.cmd == CMD_PAGE_COMPARE && !s_q.mismatch) begin
          s_d.cmd = VERIFY_OK;
        end
      end
      default: s_d.st = FDMS_IDLE;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      s_q <= '0; // normal mode after reset
    end else begin
      s_q <= s_d;
    end
  end

  fdms_op_timer u_timer (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_load(tmr_load),
    .i_count(tmr_count),
    .o_expired(tmr_expired)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  // only the core is held; peripherals see no stall and keep counting
  assign o_core_stall = (s_q.st != FDMS_IDLE);
  assign o_irq_hold = (s_q.st != FDMS_IDLE);
  assign o_page_addr_high = s_q.addr_hi;
  assign o_page_addr_low = s_q.addr_lo;
  assign o_page_data_bytes = s_q.data;
  assign o_flash_command_reg = s_q.cmd;
  assign o_program_download_mode = s_q.program_download_mode;
  assign o_prog_fault = s_q.fault;
  assign o_mem_wdata = s_q.data[s_q.idx];

  always_comb begin
    if (s_q.program_download_mode || one_byte) begin
      o_mem_addr = one_byte && !s_q.program_download_mode ? {4'h0, s_q.addr_hi[3:0], s_q.addr_lo}
        : {s_q.addr_hi, s_q.addr_lo};
    end else if (s_q.cmd == CMD_PAGE_ERASE) begin
      o_mem_addr = {4'h0, page_idx, 2'h0};
    end else begin
      o_mem_addr = {4'h0, page_idx, s_q.idx};
    end
  end

  logic work_first;
  assign work_first = (s_q.st == FDMS_WORK) && !s_q.bytes_done;
  assign o_mem_rd = work_first && byte_loop && !s_q.phase;
  // programming only lands on a byte that still reads erased
  assign o_mem_wr = work_first && byte_loop && s_q.phase && (i_mem_rdata == ERASED_BYTE)
    && ((s_q.cmd == CMD_PAGE_PROGRAM) || (s_q.cmd == CMD_BYTE_PROGRAM));
  assign o_mem_erase_page = work_first && (s_q.cmd == CMD_PAGE_ERASE);
  assign o_mem_erase_all = work_first && (s_q.cmd == CMD_ERASE_WHOLE);
  assign o_mem_page_load = work_first && s_q.program_download_mode && (s_q.cmd == CMD_PAGE_PROGRAM);

  ////////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  AST_START_IMMEDIATE: assert property (starts_op |=> o_core_stall)
    else $error("operation did not start on command write");
  AST_STALL_HOLDS: assert property (starts_op |=> o_core_stall [*8])
    else $error("stall dropped too early");
  AST_IRQ_HELD: assert property (o_core_stall |-> o_irq_hold)
    else $error("interrupts not held during operation");
  AST_RESERVED_NO_STALL: assert property (cmd_wr && !is_op(i_reg_wdata, s_q.program_download_mode)
    |=> !o_core_stall)
    else $error("unsupported command stalled the core");
  AST_RELEASE_AFTER_DONE: assert property ((s_q.st == FDMS_DONE) |=> !o_core_stall)
    else $error("stall not released after completion");
  AST_PROGRAM_ERASED: assert property (o_mem_wr |-> i_mem_rdata == ERASED_BYTE)
    else $error("program issued on a non-erased byte");
  AST_ERASE_ALIGNED: assert property (o_mem_erase_page && !s_q.program_download_mode
    |-> o_mem_addr[1:0] == 2'h0)
    else $error("page erase not page aligned");
  AST_PAGE_READ_TIME: assert property (starts_op && i_reg_wdata == CMD_PAGE_READ
    |=> o_core_stall [*8] ##[17:20] !o_core_stall)
    else $error("page read duration wrong");
  AST_ERASE_ALL_PULSE: assert property (starts_op && i_reg_wdata == CMD_ERASE_WHOLE
    |=> o_mem_erase_all)
    else $error("erase-all not issued");
  AST_DOWNLOAD_ENTER: assert property (cmd_wr && i_reg_wdata == CMD_DOWNLOAD
    |=> o_program_download_mode)
    else $error("download mode not entered");
  AST_VERIFY_OK: assert property ((s_q.st == FDMS_DONE) && s_q.cmd == CMD_PAGE_COMPARE
    && !s_q.mismatch |=> o_flash_command_reg == VERIFY_OK)
    else $error("verify match did not read zero");

  COV_PAGE_READ: cover property (starts_op && i_reg_wdata == CMD_PAGE_READ);
  COV_PAGE_PROGRAM: cover property ((s_q.st == FDMS_DONE) && (s_q.cmd == CMD_PAGE_PROGRAM)
    && !s_q.fault);
  COV_VERIFY_MISMATCH: cover property ((s_q.st == FDMS_DONE) && s_q.mismatch);
  COV_ERASE_ALL: cover property (o_mem_erase_all);

endmodule : fdms_sequencer
`default_nettype wire

// [inc/fdms_pkg.sv]
// fdms_pkg: constants, timing counts and types for the data flash sequencer.
// Assumes a single 10 MHz system clock and one machine cycle per clock.
package fdms_pkg;

  // clock and timing
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned PAGE_RD_MC = 25;
  localparam int unsigned BYTE_RD_MC = 10;
  localparam int unsigned PAGE_WR_NS = 380000;
  localparam int unsigned BYTE_WR_NS = 200000;
  localparam int unsigned ERASE_NS = 2000000;
  localparam int unsigned PROGRAM_DOWNLOAD_MODE_WR_NS = 15000000;
  // typical times, rounded down to whole cycles
  localparam int unsigned PAGE_WR_CYC = PAGE_WR_NS / CLK_PERIOD_NS;
  localparam int unsigned BYTE_WR_CYC = BYTE_WR_NS / CLK_PERIOD_NS;
  localparam int unsigned ERASE_CYC = ERASE_NS / CLK_PERIOD_NS;
  localparam int unsigned PROGRAM_DOWNLOAD_MODE_WR_CYC = PROGRAM_DOWNLOAD_MODE_WR_NS / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 18;

  // array geometry
  localparam int unsigned PAGE_BYTES = 4;
  localparam int unsigned PAGE_COUNT = 1024;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // register select codes on the write port
  localparam logic [2:0] SEL_ADDR_HIGH = 3'h0;
  localparam logic [2:0] SEL_ADDR_LOW = 3'h1;
  localparam logic [2:0] SEL_DATA0 = 3'h2;
  localparam logic [2:0] SEL_CMD = 3'h6;

  // command codes
  localparam logic [7:0] CMD_PAGE_READ = 8'h01;
  localparam logic [7:0] CMD_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] CMD_PAGE_COMPARE = 8'h04;
  localparam logic [7:0] CMD_PAGE_ERASE = 8'h05;
  localparam logic [7:0] CMD_ERASE_WHOLE = 8'h06;
  localparam logic [7:0] CMD_BYTE_READ = 8'h81;
  localparam logic [7:0] CMD_BYTE_PROGRAM = 8'h82;
  localparam logic [7:0] CMD_EXIT_DOWNLOAD = 8'h0F;
  localparam logic [7:0] CMD_DOWNLOAD = 8'hF0;
  localparam logic [7:0] VERIFY_OK = 8'h00;

  typedef enum logic [1:0] {
    FDMS_IDLE = 2'b00,
    FDMS_WORK = 2'b01,
    FDMS_DONE = 2'b11
  } fdms_state_e;

endpackage : fdms_pkg

// [src/fdms_op_timer.sv]
// fdms_op_timer: down counter that times one flash operation.
// Assumes the loader gives a count of at least one cycle.
`timescale 1ns/1ps
`default_nettype none

module fdms_op_timer (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_load,
  input wire logic [fdms_pkg::CNT_W-1:0] i_count,
  output logic o_expired
);
  import fdms_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } fdms_tmr_s;

  fdms_tmr_s s_q;
  fdms_tmr_s s_d;

  always_comb begin
    s_d = s_q;
    if (i_load) begin
      s_d.cnt = i_count;
    end else if (s_q.cnt != '0) begin
      s_d.cnt = s_q.cnt - CNT_W'(1);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // a load in the same cycle keeps the old expiry from leaking through
  assign o_expired = (s_q.cnt == '0) && !i_load;

endmodule : fdms_op_timer
`default_nettype wire

// [testbench/fdms_flash_model.sv]
// fdms_flash_model: byte-wide data flash macro behind the sequencer.
// Assumes one-cycle read latency; program memory in download mode is not stored.
`timescale 1ns/1ps
`default_nettype none

module fdms_flash_model (
  input wire logic i_clk_sys,
  input wire logic i_prog_sel,
  input wire logic [15:0] i_mem_addr,
  input wire logic [7:0] i_mem_wdata,
  input wire logic i_mem_rd,
  input wire logic i_mem_wr,
  input wire logic i_mem_erase_page,
  input wire logic i_mem_erase_all,
  output logic [7:0] o_mem_rdata
);
  // 1024 pages of four bytes, shipped erased
  logic [7:0] mem [0:4095];

  initial begin
    foreach (mem[i]) mem[i] = 8'hFF;
    o_mem_rdata = 8'h00;
  end

  always @(posedge i_clk_sys) begin
    // bus not held between reads: toggles so a stale sample shows up
    if (i_mem_rd) begin
      o_mem_rdata <= mem[i_mem_addr[11:0]];
    end else begin
      o_mem_rdata <= ~o_mem_rdata;
    end
    if (!i_prog_sel) begin
      // programming only clears bits, so a non-erased target gets corrupted
      if (i_mem_wr) begin
        mem[i_mem_addr[11:0]] <= mem[i_mem_addr[11:0]] & i_mem_wdata;
      end
      if (i_mem_erase_page) begin
        for (int i = 0; i < 4; i++) mem[{i_mem_addr[11:2], 2'(i)}] <= 8'hFF;
      end
      if (i_mem_erase_all) begin
        foreach (mem[i]) mem[i] <= 8'hFF;
      end
    end
  end
endmodule : fdms_flash_model
`default_nettype wire

// [testbench/tb_fdms_sequencer.sv]
// tb_fdms_sequencer: directed scenarios for the data flash sequencer.
// Assumes the flash model above as macro; the bench plays the core.
`timescale 1ns/1ps
`default_nettype none

module tb_fdms_sequencer;
  import fdms_pkg::*;
  // short erase and download times keep the run brief
  localparam int ER = 50;
  localparam int UW = 60;
  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  logic i_reg_wr = 1'b0;
  logic [2:0] i_reg_sel = 3'h0;
  logic [7:0] i_reg_wdata = 8'h00;
  logic [7:0] i_mem_rdata;
  logic [7:0] o_page_addr_high, o_page_addr_low, o_flash_command_reg, o_mem_wdata;
  logic [31:0] o_page_data_bytes;
  logic [15:0] o_mem_addr;
  logic o_program_download_mode, o_prog_fault, o_core_stall, o_irq_hold;
  logic o_mem_rd, o_mem_wr, o_mem_erase_page, o_mem_erase_all, o_mem_page_load;
  int err_count = 0;
  int num_checks = 0;
  int cyc = 0;
  int len;
  int pulses;

  fdms_sequencer #(.P_ERASE_CYC(CNT_W'(ER)), .P_PROGRAM_DOWNLOAD_MODE_WR_CYC(CNT_W'(UW))) u_dut (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_reg_wr(i_reg_wr), .i_reg_sel(i_reg_sel),
    .i_reg_wdata(i_reg_wdata), .i_mem_rdata(i_mem_rdata),
    .o_page_addr_high(o_page_addr_high), .o_page_addr_low(o_page_addr_low),
    .o_page_data_bytes(o_page_data_bytes), .o_flash_command_reg(o_flash_command_reg),
    .o_program_download_mode(o_program_download_mode), .o_prog_fault(o_prog_fault),
    .o_core_stall(o_core_stall), .o_irq_hold(o_irq_hold), .o_mem_addr(o_mem_addr),
    .o_mem_wdata(o_mem_wdata), .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr),
    .o_mem_erase_page(o_mem_erase_page), .o_mem_erase_all(o_mem_erase_all),
    .o_mem_page_load(o_mem_page_load));

  fdms_flash_model u_mem (
    .i_clk_sys(i_clk_sys), .i_prog_sel(o_program_download_mode), .i_mem_addr(o_mem_addr),
    .i_mem_wdata(o_mem_wdata), .i_mem_rd(o_mem_rd), .i_mem_wr(o_mem_wr),
    .i_mem_erase_page(o_mem_erase_page), .i_mem_erase_all(o_mem_erase_all),
    .o_mem_rdata(i_mem_rdata));

  initial begin
    forever #50 i_clk_sys = ~i_clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop

  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      report_and_stop();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic wr_reg(input logic [2:0] sel, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_reg_wr <= 1'b1;
    i_reg_sel <= sel;
    i_reg_wdata <= d;
    @(posedge i_clk_sys);
    i_reg_wr <= 1'b0;
    // register outputs update in this same time step; look only once they have settled
    #1;
  endtask : wr_reg

  // counts stall cycles and macro erase/load pulses, bounded wait
  task automatic wait_done;
    #1;
    len = 0;
    pulses = 0;
    while (o_core_stall === 1'b1 && len < 5000) begin
      check(o_irq_hold, o_core_stall);
      pulses += o_mem_erase_page + o_mem_erase_all + o_mem_page_load;
      len++;
      @(posedge i_clk_sys);
      #1;
    end
  endtask : wait_done

  task automatic cmd(input logic [7:0] c);
    wr_reg(SEL_CMD, c);
    wait_done();
  endtask : cmd

  // stall must start on the command edge and last about the op time
  task automatic check_len(input int n);
    check(32'(len >= n && len <= n + 2), 32'h1);
  endtask : check_len

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_and_page;
    check({o_program_download_mode, o_core_stall, o_flash_command_reg}, 32'h0);
    wr_reg(SEL_ADDR_HIGH, 8'h03);
    wr_reg(SEL_ADDR_LOW, 8'hFF);
    check({o_page_addr_high, o_page_addr_low}, 32'h03FF);
    cmd(CMD_ERASE_WHOLE);
    check_len(ER);
    check(pulses, 1);
    cmd(CMD_PAGE_READ);
    check_len(25);
    check(o_page_data_bytes, 32'hFFFFFFFF);
    $display("test reset_and_page done");
  endtask : t_reset_and_page

  task automatic t_modify_page;
    {u_mem.mem[15], u_mem.mem[14], u_mem.mem[13], u_mem.mem[12]} = 32'h44332211;
    u_mem.mem[16] = 8'h55;
    wr_reg(SEL_ADDR_HIGH, 8'h00);
    wr_reg(SEL_ADDR_LOW, 8'h03);
    cmd(CMD_PAGE_READ);
    check(o_page_data_bytes, 32'h44332211);
    wr_reg(SEL_DATA0 + 3'h1, 8'hF3);
    cmd(CMD_PAGE_ERASE);
    check_len(ER);
    check({u_mem.mem[16], u_mem.mem[15], u_mem.mem[12], u_mem.mem[11]}, 32'h55FFFFFF);
    cmd(CMD_PAGE_PROGRAM);
    check_len(3800);
    check({u_mem.mem[15], u_mem.mem[14], u_mem.mem[13], u_mem.mem[12]}, 32'h4433F311);
    cmd(CMD_PAGE_COMPARE);
    check_len(25);
    check(o_flash_command_reg, VERIFY_OK);
    wr_reg(SEL_DATA0 + 3'h3, 8'h00);
    cmd(CMD_PAGE_COMPARE);
    check(32'(o_flash_command_reg != 8'h00), 32'h1);
    cmd(CMD_PAGE_PROGRAM);
    check({o_prog_fault, u_mem.mem[15]}, 32'h144);
    $display("test modify_page done");
  endtask : t_modify_page

  task automatic t_single_byte;
    wr_reg(SEL_ADDR_HIGH, 8'h0F);
    wr_reg(SEL_ADDR_LOW, 8'hFF);
    wr_reg(SEL_DATA0, 8'h5A);
    cmd(CMD_BYTE_PROGRAM);
    check_len(2000);
    check(u_mem.mem[4095], 8'h5A);
    wr_reg(SEL_DATA0, 8'h00);
    cmd(CMD_BYTE_READ);
    check_len(10);
    check(o_page_data_bytes[7:0], 8'h5A);
    $display("test single_byte done");
  endtask : t_single_byte

  task automatic t_refusals;
    cmd(8'h03);
    check(len, 0);
    wr_reg(SEL_CMD, CMD_PAGE_ERASE);
    wr_reg(SEL_ADDR_LOW, 8'h77);
    wait_done();
    check(o_page_addr_low, 8'hFF);
    $display("test refusals done");
  endtask : t_refusals

  task automatic t_download;
    cmd(CMD_DOWNLOAD);
    check({len[30:0], o_program_download_mode}, 32'h1);
    cmd(CMD_PAGE_PROGRAM);
    check_len(UW);
    check(pulses, 1);
    cmd(CMD_PAGE_ERASE);
    check_len(ER);
    cmd(CMD_PAGE_READ);
    check(len, 0);
    cmd(CMD_EXIT_DOWNLOAD);
    check({len[30:0], o_program_download_mode}, 32'h0);
    $display("test download done");
  endtask : t_download

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    t_reset_and_page();
    t_modify_page();
    t_single_byte();
    t_refusals();
    t_download();
    report_and_stop();
  end
endmodule : tb_fdms_sequencer
`default_nettype wire
